/* File: hw/sarct_top.sv */
// Notes on behaviour
// (R1) acquisition code zero tracks exactly one conversion clock before hold
// (R2) conversion clock is master clock divided by 1,2,4,8; code 2 gives 4
// (R3) conversion lasts acquisition clocks plus one sync plus fifteen steps
// (R4) continuous mode restarts at once when a conversion completes
// (R5) reference off after reset; on while converter or either dac enabled
// (R6) software waits about 65 ms after reference enable before converting
// (R7) software keeps the conversion clock between 400 kHz and 4 MHz
// (R8) busy flag is set for a whole conversion and cleared by hardware
// (R9) acquisition code n selects n+1 conversion clocks
`timescale 1ns/10ps
module sarct_top (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // register bus
  input  wire sarct_pkg::sarct_axi_req_t axi_req,
  output      sarct_pkg::sarct_axi_rsp_t axi_rsp,
  // converter timing
  output      sarct_pkg::sarct_conv_t    conv,
  // interrupt
  output      logic                     irq
);

  typedef struct packed {
    sarct_pkg::sarct_axi_rsp_t rsp;
    logic [7:0]                ctrl_one;
    logic                      cont;
    logic                      dac0;
    logic                      dac1;
    logic [1:0]                status;
    logic [1:0]                mask;
    logic [2:0]                div_cnt;
    logic                      tick;
    sarct_pkg::sarct_state_t   st;
    logic [3:0]                phase;
    logic [1:0]                acq;
    sarct_pkg::sarct_conv_t    out;
    logic                      irq;
    logic [4:0]                tick_cnt;
  } sarct_regs_t;

  sarct_regs_t q_ff;
  sarct_regs_t nxt_q;

  logic [1:0] div_sel;
  logic [1:0] acq_sel;
  logic       pwr;
  assign div_sel = q_ff.ctrl_one[sarct_pkg::DIV_LSB +: 2];
  assign acq_sel = q_ff.ctrl_one[sarct_pkg::ACQ_LSB +: 2];
  assign pwr     = q_ff.ctrl_one[sarct_pkg::PWR_BIT];

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic        start;
    logic [2:0]  ratio_m1;
    rd       = 32'h0000_0000;
    hit      = 1'b1;
    start    = 1'b0;
    ratio_m1 = 3'((4'h1 << div_sel) - 4'h1);
    nxt_q    = q_ff;
    nxt_q.rsp.awready     = 1'b0;
    nxt_q.rsp.wready      = 1'b0;
    nxt_q.rsp.arready     = 1'b0;
    nxt_q.out.sar_step    = 1'b0;
    nxt_q.out.conv_done   = 1'b0;

    // write: address and data taken together, one write in flight
    if (axi_req.awvalid && axi_req.wvalid && !q_ff.rsp.awready &&
        !q_ff.rsp.bvalid) begin
      nxt_q.rsp.awready = 1'b1;
      nxt_q.rsp.wready  = 1'b1;
    end
    if (q_ff.rsp.awready) begin
      nxt_q.rsp.bvalid = 1'b1;
      nxt_q.rsp.bresp  = sarct_pkg::RESP_OKAY;
      if (axi_req.wstrb[0]) begin
        case (axi_req.awaddr)
          sarct_pkg::OFF_CTRL_ONE: begin
            nxt_q.ctrl_one = axi_req.wdata[7:0];
          end
          sarct_pkg::OFF_CTRL_TWO: begin
            nxt_q.cont = axi_req.wdata[sarct_pkg::CONT_BIT];
            nxt_q.dac0 = axi_req.wdata[sarct_pkg::DAC0_BIT];
            nxt_q.dac1 = axi_req.wdata[sarct_pkg::DAC1_BIT];
            start      = axi_req.wdata[sarct_pkg::START_BIT];
          end
          sarct_pkg::OFF_MASK: begin
            nxt_q.mask = axi_req.wdata[1:0];
          end
          sarct_pkg::OFF_CTRL_THREE, sarct_pkg::OFF_STATUS: begin
          end
          default: begin
            nxt_q.rsp.bresp = sarct_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    if (q_ff.rsp.bvalid && axi_req.bready) begin
      nxt_q.rsp.bvalid = 1'b0;
    end

    // read: status clears when read, events below may set again
    if (axi_req.arvalid && !q_ff.rsp.arready && !q_ff.rsp.rvalid) begin
      nxt_q.rsp.arready = 1'b1;
    end
    if (q_ff.rsp.arready) begin
      case (axi_req.araddr)
        sarct_pkg::OFF_CTRL_ONE: begin
          rd[7:0] = q_ff.ctrl_one;
        end
        sarct_pkg::OFF_CTRL_TWO: begin
          rd[sarct_pkg::CONT_BIT] = q_ff.cont;
          rd[sarct_pkg::DAC0_BIT] = q_ff.dac0;
          rd[sarct_pkg::DAC1_BIT] = q_ff.dac1;
        end
        sarct_pkg::OFF_CTRL_THREE: begin
          rd[sarct_pkg::BUSY_BIT] = q_ff.out.busy; // R8
        end
        sarct_pkg::OFF_STATUS: begin
          rd[1:0]      = q_ff.status;
          nxt_q.status = sarct_pkg::RST_EVENTS;
        end
        sarct_pkg::OFF_MASK: begin
          rd[1:0] = q_ff.mask;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      nxt_q.rsp.rvalid = 1'b1;
      nxt_q.rsp.rdata  = rd;
      nxt_q.rsp.rresp  = hit ? sarct_pkg::RESP_OKAY
                             : sarct_pkg::RESP_SLVERR;
    end
    if (q_ff.rsp.rvalid && axi_req.rready) begin
      nxt_q.rsp.rvalid = 1'b0;
    end

    // conversion clock enable, free running
    if (q_ff.div_cnt >= ratio_m1) begin // R2
      nxt_q.div_cnt = 3'h0;
      nxt_q.tick    = 1'b1;
    end else begin
      nxt_q.div_cnt = q_ff.div_cnt + 3'h1;
      nxt_q.tick    = 1'b0;
    end

    // conversion sequence counted in conversion clocks
    case (q_ff.st)
      sarct_pkg::ST_IDLE: begin
        if (pwr && (start || q_ff.cont)) begin
          nxt_q.st        = sarct_pkg::ST_ACQ;
          nxt_q.phase     = 4'h0;
          nxt_q.acq       = acq_sel;
          nxt_q.out.track = 1'b1;
          nxt_q.out.busy  = 1'b1; // R8
        end
      end
      sarct_pkg::ST_ACQ: begin
        if (q_ff.tick) begin
          if (q_ff.phase[1:0] == q_ff.acq) begin // R1 R9
            nxt_q.st        = sarct_pkg::ST_SYNC;
            nxt_q.phase     = 4'h0;
            nxt_q.out.track = 1'b0;
          end else begin
            nxt_q.phase = q_ff.phase + 4'h1;
          end
        end
      end
      sarct_pkg::ST_SYNC: begin
        if (q_ff.tick) begin
          nxt_q.st = sarct_pkg::ST_CONV;
        end
      end
      sarct_pkg::ST_CONV: begin
        if (q_ff.tick) begin
          nxt_q.out.sar_step = 1'b1;
          if (q_ff.phase == sarct_pkg::CONV_CLKS - 4'h1) begin // R3
            nxt_q.out.conv_done = 1'b1;
            nxt_q.phase         = 4'h0;
            if (pwr && q_ff.cont) begin // R4
              nxt_q.st        = sarct_pkg::ST_ACQ;
              nxt_q.acq       = acq_sel;
              nxt_q.out.track = 1'b1;
            end else begin
              nxt_q.st       = sarct_pkg::ST_IDLE;
              nxt_q.out.busy = 1'b0; // R8
            end
          end else begin
            nxt_q.phase = q_ff.phase + 4'h1;
          end
        end
      end
      default: begin
        nxt_q.st = sarct_pkg::ST_IDLE;
      end
    endcase
    // powering down abandons a conversion in progress
    if (!pwr) begin
      nxt_q.st        = sarct_pkg::ST_IDLE;
      nxt_q.out.track = 1'b0;
      nxt_q.out.busy  = 1'b0;
      // an aborted conversion must not report a result
      nxt_q.out.sar_step  = 1'b0;
      nxt_q.out.conv_done = 1'b0;
    end

    // reference follows converter and dac enables
    nxt_q.out.ref_on = pwr || q_ff.dac0 || q_ff.dac1; // R5

    // events set after the read clear so a coincident event survives
    if (nxt_q.out.conv_done) begin
      nxt_q.status[sarct_pkg::EV_DONE] = 1'b1;
    end
    if (nxt_q.out.ref_on && !q_ff.out.ref_on) begin
      nxt_q.status[sarct_pkg::EV_REF] = 1'b1;
    end
    nxt_q.irq = |(nxt_q.status & nxt_q.mask);

    // conversion clocks seen during one conversion, for checking only
    if (q_ff.st == sarct_pkg::ST_IDLE) begin
      nxt_q.tick_cnt = 5'h00;
    end else if (q_ff.out.conv_done) begin
      nxt_q.tick_cnt = q_ff.tick ? 5'h01 : 5'h00;
    end else if (q_ff.tick) begin
      nxt_q.tick_cnt = q_ff.tick_cnt + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_ff          <= '0;
      q_ff.ctrl_one <= sarct_pkg::RST_CTRL_ONE;
      q_ff.status   <= sarct_pkg::RST_EVENTS;
      q_ff.st       <= sarct_pkg::ST_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign axi_rsp = q_ff.rsp;
  assign conv    = q_ff.out;
  assign irq     = q_ff.irq;

  a_acq_one_clk: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (q_ff.st == sarct_pkg::ST_ACQ && q_ff.acq == 2'h0 && q_ff.tick && pwr)
    |=> q_ff.st == sarct_pkg::ST_SYNC && !q_ff.out.track)
    else $error("acquisition code zero did not hold after one clock");

  a_div_by_four: assert property (@(posedge sys_clk) disable iff (rst) // R2
    (q_ff.tick && div_sel == 2'h2 && $past(div_sel) == 2'h2)
    |=> (!q_ff.tick && div_sel == 2'h2) [*3] ##1 q_ff.tick)
    else $error("divide by four tick spacing wrong");

  // a continuous restart relatches the code at the done edge, so use the old
  a_conv_length: assert property (@(posedge sys_clk) disable iff (rst) // R3
    q_ff.out.conv_done
    |-> q_ff.tick_cnt == {3'h0, $past(q_ff.acq)} + 5'h01
                         + sarct_pkg::SYNC_CLKS
                         + {1'b0, sarct_pkg::CONV_CLKS})
    else $error("conversion length not acquisition plus sixteen");

  a_cont_restart: assert property (@(posedge sys_clk) disable iff (rst) // R4
    (q_ff.st == sarct_pkg::ST_CONV && q_ff.tick && q_ff.cont && pwr &&
     q_ff.phase == 4'hE)
    |=> q_ff.out.conv_done && q_ff.out.busy &&
        q_ff.st == sarct_pkg::ST_ACQ)
    else $error("continuous mode did not restart at once");

  a_ref_follow: assert property (@(posedge sys_clk) disable iff (rst) // R5
    ##1 q_ff.out.ref_on == $past(pwr || q_ff.dac0 || q_ff.dac1))
    else $error("reference enable does not follow enables");

  a_busy_span: assert property (@(posedge sys_clk) disable iff (rst) // R8
    q_ff.out.busy == (q_ff.st != sarct_pkg::ST_IDLE))
    else $error("busy flag disagrees with conversion in progress");

  a_busy_clear: assert property (@(posedge sys_clk) disable iff (rst) // R8
    $fell(q_ff.out.busy) && pwr |-> q_ff.out.conv_done)
    else $error("busy cleared without conversion end");

  a_acq_len: assert property (@(posedge sys_clk) disable iff (rst) // R9
    q_ff.st == sarct_pkg::ST_ACQ |-> q_ff.phase[1:0] <= q_ff.acq &&
                                     q_ff.phase[3:2] == 2'h0)
    else $error("acquisition ran past selected length");

  a_hold_phase: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (q_ff.st == sarct_pkg::ST_SYNC || q_ff.st == sarct_pkg::ST_CONV)
    |-> !q_ff.out.track)
    else $error("track still high after acquisition");

  a_sync_len: assert property (@(posedge sys_clk) disable iff (rst) // R3
    (q_ff.st == sarct_pkg::ST_SYNC && q_ff.tick && pwr)
    |=> q_ff.st == sarct_pkg::ST_CONV && q_ff.phase == 4'h0)
    else $error("synchronisation did not last one clock");

  a_step_conv: assert property (@(posedge sys_clk) disable iff (rst) // R3
    q_ff.out.sar_step
    |-> $past(q_ff.st == sarct_pkg::ST_CONV && q_ff.tick))
    else $error("step pulse outside a conversion clock");

  a_ref_reset: assert property (@(posedge sys_clk) disable iff (rst) // R5
    $fell(rst) |-> !q_ff.out.ref_on)
    else $error("reference on after reset");

endmodule : sarct_top

/* File: hw/sarct_pkg.sv */
package sarct_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL_ONE   = 5'h00;
  localparam logic [4:0] OFF_CTRL_TWO   = 5'h04;
  localparam logic [4:0] OFF_CTRL_THREE = 5'h08;
  localparam logic [4:0] OFF_STATUS     = 5'h0C;
  localparam logic [4:0] OFF_MASK       = 5'h10;

  // field positions
  localparam int ACQ_LSB   = 2;
  localparam int DIV_LSB   = 4;
  localparam int PWR_BIT   = 6;
  localparam int START_BIT = 0;
  localparam int CONT_BIT  = 1;
  localparam int DAC0_BIT  = 4;
  localparam int DAC1_BIT  = 5;
  localparam int BUSY_BIT  = 7;
  localparam int EV_DONE   = 0;
  localparam int EV_REF    = 1;

  // values after reset
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [1:0] RST_EVENTS   = 2'h0;

  // conversion clock counts
  localparam logic [3:0] CONV_CLKS = 4'hF;
  localparam logic [4:0] SYNC_CLKS = 5'h01;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_SYNC, ST_CONV} sarct_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [4:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [4:0]  araddr;
    logic        rready;
  } sarct_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sarct_axi_rsp_t;

  typedef struct packed {
    logic track;
    logic sar_step;
    logic conv_done;
    logic busy;
    logic ref_on;
  } sarct_conv_t;

endpackage : sarct_pkg

/* File: test/sarct_tb.sv */
`timescale 1ns/10ps
module tb;
  logic                      sys_clk;
  logic                      rst;
  sarct_pkg::sarct_axi_req_t req;
  sarct_pkg::sarct_axi_rsp_t rsp;
  sarct_pkg::sarct_conv_t    conv;
  logic                      irq;
  int mismatches, cmp_count, done_cnt, busy_n, trk_n, step_n, since;
  int res_busy, res_trk, res_step, gap_bad, low_n;

  sarct_top uut (
    .sys_clk(sys_clk),
    .rst    (rst),
    .axi_req(req),
    .axi_rsp(rsp),
    .conv   (conv),
    .irq    (irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // per-conversion counts, latched on the done pulse
  always @(posedge sys_clk) begin
    since = since + 1;
    if (conv.busy !== 1'b1) low_n = low_n + 1;
    // the last step pulse shares its cycle with the done pulse
    if (conv.sar_step === 1'b1) begin
      if (step_n > 0 && since != 4) gap_bad = gap_bad + 1;
      step_n = step_n + 1;
      since = 0;
    end
    if (conv.conv_done === 1'b1) begin
      res_busy = busy_n;
      res_trk  = trk_n;
      res_step = step_n;
      busy_n = 0;
      trk_n = 0;
      step_n = 0;
      done_cnt = done_cnt + 1;
    end else if (conv.busy === 1'b1) begin
      busy_n = busy_n + 1;
      if (conv.track === 1'b1) trk_n = trk_n + 1;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic timeout();
    mismatches++;
    $display("ERROR %0t wait limit reached", $time);
    finish_test();
  endtask : timeout

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string m);
    cmp_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("ERROR %0t %s got %0d", $time, m, got);
    end
  endtask : chk_rng

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin @(posedge sys_clk); n++; end
    while (!(rsp.awready === 1'b1 && rsp.wready === 1'b1) && n < 50);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    while (rsp.bvalid !== 1'b1 && n < 50) begin @(posedge sys_clk); n++; end
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (n >= 50) timeout();
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin @(posedge sys_clk); n++; end
    while (rsp.arready !== 1'b1 && n < 50);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1 && n < 50) begin @(posedge sys_clk); n++; end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (n >= 50) timeout();
  endtask : rd

  task automatic wait_done(input int k);
    int n;
    n = 0;
    while (done_cnt < k && n < 2000) begin @(posedge sys_clk); n++; end
    if (n >= 2000) timeout();
  endtask : wait_done

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    chk(32'(conv.ref_on), 32'h0000_0000, "ref after reset");
    chk(32'(irq), 32'h0000_0000, "irq after reset");
    rd(sarct_pkg::OFF_CTRL_ONE, d, r);
    chk(d, 32'(sarct_pkg::RST_CTRL_ONE), "ctrl one reset");
    rd(5'h14, d, r);
    chk(32'(r), 32'(sarct_pkg::RESP_SLVERR), "unmapped answer");
    wr(5'h14, 32'h0000_0000, r);
    chk(32'(r), 32'(sarct_pkg::RESP_SLVERR), "unmapped write");
    $display("test reset done");
  endtask : t_reset

  task automatic t_ref();
    logic [31:0] d;
    logic [1:0]  r;
    wr(sarct_pkg::OFF_CTRL_TWO, 32'h0000_0010, r);
    chk(32'(r), 32'(sarct_pkg::RESP_OKAY), "write answer");
    tick(2);
    chk(32'(conv.ref_on), 32'h0000_0001, "ref by dac");
    wr(sarct_pkg::OFF_CTRL_TWO, 32'h0000_0020, r);
    tick(2);
    chk(32'(conv.ref_on), 32'h0000_0001, "ref by second dac");
    wr(sarct_pkg::OFF_CTRL_TWO, 32'h0000_0000, r);
    tick(2);
    chk(32'(conv.ref_on), 32'h0000_0000, "ref off");
    wr(sarct_pkg::OFF_CTRL_ONE, 32'h0000_0040, r);
    tick(2);
    chk(32'(conv.ref_on), 32'h0000_0001, "ref by power");
    // reference settle wait before any conversion, scaled to keep runs short
    tick(64);
    rd(sarct_pkg::OFF_STATUS, d, r);
    chk(32'(d[1]), 32'h0000_0001, "ref event");
    wr(sarct_pkg::OFF_MASK, 32'h0000_0001, r);
    $display("test reference done");
  endtask : t_ref

  // divider code 2 throughout, so one conversion clock is 4 cycles;
  // the analog rate limit scales with this fast bench clock
  task automatic t_conv(input int n);
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    wr(sarct_pkg::OFF_CTRL_ONE, 32'h0000_0060 | 32'(n << 2), r);
    k = done_cnt;
    wr(sarct_pkg::OFF_CTRL_TWO, 32'h0000_0001, r);
    rd(sarct_pkg::OFF_CTRL_THREE, d, r);
    chk(32'(d[7]), 32'h0000_0001, "busy flag");
    wait_done(k + 1);
    tick(2);
    chk(32'(conv.busy), 32'h0000_0000, "busy cleared");
    chk_rng(res_step, 15, 15, "step count");
    chk_rng(gap_bad, 0, 0, "step spacing");
    chk_rng(res_trk, 4 * n + 1, 4 * n + 5, "track length");
    chk_rng(res_busy, 4 * n + 64, 4 * n + 70, "conv length");
    chk(32'(irq), 32'h0000_0001, "irq raised");
    rd(sarct_pkg::OFF_STATUS, d, r);
    chk(32'(d[0]), 32'h0000_0001, "done event");
    tick(2);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    $display("test single conversion %0d done", n);
  endtask : t_conv

  task automatic t_cont();
    logic [1:0] r;
    int         k;
    int         lb;
    wr(sarct_pkg::OFF_CTRL_TWO, 32'h0000_0002, r);
    k = done_cnt;
    wait_done(k + 1);
    lb = low_n;
    wait_done(k + 2);
    chk_rng(low_n - lb, 0, 0, "busy gap");
    chk_rng(res_busy, 76, 82, "back to back length");
    wr(sarct_pkg::OFF_CTRL_TWO, 32'h0000_0000, r);
    wait_done(done_cnt + 1);
    tick(2);
    chk(32'(conv.busy), 32'h0000_0000, "stop after last");
    $display("test continuous done");
  endtask : t_cont

  initial begin
    rst = 1'b1;
    req = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_ref();
    for (int n = 0; n < 4; n++) t_conv(n);
    t_cont();
    finish_test();
  end
endmodule : tb
